/* adc_conversion_control.sv */
// Control logic of the successive-approximation converter
`timescale 1ns/10ps
module adc_conversion_control #(
   parameter int SAMPLE_BITS = 10,
   parameter int RESULT_BITS = 16
) (
   // Clock and reset
   input  wire logic                      clk,
   input  wire logic                      srst,
   // Register port
   input  wire logic [7:0]                reg_addr,
   input  wire logic [7:0]                reg_wdata,
   input  wire logic                      reg_write,
   input  wire logic                      reg_read,
   output logic      [7:0]                reg_rdata,
   // Sleep controller
   input  wire logic                      standby_sleep,
   input  wire logic                      deep_sleep_wake,
   // Thresholds from the window registers
   input  wire logic [RESULT_BITS-1:0]    window_low_threshold,
   input  wire logic [RESULT_BITS-1:0]    window_high_threshold,
   // Analog core
   output adc_ctrl_pkg::analog_cfg_t      analog_cfg,
   output logic                           sample_open,
   output logic                           convert_start,
   input  wire logic                      convert_done,
   input  wire logic [SAMPLE_BITS-1:0]    convert_data,
   // Results
   output logic      [RESULT_BITS-1:0]    result,
   output logic                           result_ready_flag,
   output logic                           window_flag,
   output logic                           start_conversion
);
   initial begin
      if (SAMPLE_BITS != 10 || RESULT_BITS != 16) begin
         $error("adc_conversion_control: only 10-bit samples and 16-bit results");
      end
   end

   //---------------------------------------------------------------------
   // Registers
   //---------------------------------------------------------------------
   logic [7:0] main_control_reg;
   logic [7:0] accumulation_control_reg;
   logic [7:0] clock_reference_control_reg;
   logic [7:0] delay_control_reg;
   logic [7:0] window_mode_control_reg;
   logic [7:0] sample_length_control_reg;
   logic [7:0] input_channel_select_reg;

   adc_ctrl_pkg::conv_state_t state_reg;
   logic [8:0]             tick_count_reg;
   logic [6:0]             samples_left_reg;
   logic [RESULT_BITS-1:0] accum_reg;
   logic                   startup_pending_reg;
   logic                   enable_prev_reg;
   logic                   tick;

   wire enable_bit  = main_control_reg[adc_ctrl_pkg::BIT_ENABLE];
   wire wr_clock    = reg_write && reg_addr == adc_ctrl_pkg::OFS_CLOCK_REF;
   wire wr_delay    = reg_write && reg_addr == adc_ctrl_pkg::OFS_DELAY_CONTROL;
   wire wr_command  = reg_write && reg_addr == adc_ctrl_pkg::OFS_COMMAND;
   wire start_cmd   = wr_command && reg_wdata[adc_ctrl_pkg::BIT_START_CONV];
   wire [1:0] reference_select = clock_reference_control_reg[5:4];
   wire [2:0] startup_delay    = delay_control_reg[7:5];
   wire       auto_delay_variation = delay_control_reg[adc_ctrl_pkg::BIT_AUTO_DELAY];
   wire [3:0] inter_sample_delay   = delay_control_reg[3:0];
   wire [2:0] accumulation_count   = accumulation_control_reg[2:0];
   wire [2:0] window_mode          = window_mode_control_reg[2:0];
   wire [4:0] sample_length_extension = sample_length_control_reg[4:0];
   wire       continuous_conversion = main_control_reg[adc_ctrl_pkg::BIT_CONTINUOUS];
   wire       resolution_select     = main_control_reg[adc_ctrl_pkg::BIT_RESOLUTION];

   // Converter runs when enabled and not halted by standby
   wire active = enable_bit &&
                 (!standby_sleep || main_control_reg[adc_ctrl_pkg::BIT_STANDBY_RUN]); // [R1] [R5]

   //---------------------------------------------------------------------
   // Helper functions
   //---------------------------------------------------------------------
   function automatic logic [6:0] sample_total(input logic [2:0] code);
      // Reserved code behaves as a single sample
      if (code > adc_ctrl_pkg::ACCUM_MAX_CODE) begin
         sample_total = 7'h01;
      end else begin
         sample_total = 7'(7'h01 << code); // [R6]
      end
   endfunction

   function automatic logic [8:0] startup_ticks(input logic [2:0] code);
      // Reserved codes give no delay
      if (code == 3'h0 || code > adc_ctrl_pkg::STARTUP_MAX_CODE) begin
         startup_ticks = 9'h000;
      end else begin
         startup_ticks = 9'(adc_ctrl_pkg::STARTUP_BASE_TICKS << (code - 3'h1)); // [R10]
      end
   endfunction

   function automatic logic window_match(input logic [2:0] mode,
                                         input logic [15:0] value,
                                         input logic [15:0] low,
                                         input logic [15:0] high);
      unique case (mode)
         adc_ctrl_pkg::WIN_BELOW:   window_match = value < low;
         adc_ctrl_pkg::WIN_ABOVE:   window_match = value > high;
         adc_ctrl_pkg::WIN_INSIDE:  window_match = (value > low) && (value < high);
         adc_ctrl_pkg::WIN_OUTSIDE: window_match = (value < low) || (value > high);
         default:                   window_match = 1'b0; // [R14]
      endcase
   endfunction
   wire startup_end = tick && tick_count_reg + 9'h001 >= startup_ticks(startup_delay);
   wire sample_end  = tick && tick_count_reg + 9'h001 >=
                      adc_ctrl_pkg::SAMPLE_BASE_TICKS + 9'(sample_length_extension);
   wire gap_end     = tick && tick_count_reg + 9'h001 >= 9'(inter_sample_delay);

   //---------------------------------------------------------------------
   // Converter clock
   //---------------------------------------------------------------------
   clock_prescaler #(
      .MAX_CODE           (7)
   ) u_prescaler (
      .clk                (clk),
      .srst               (srst),
      .run                (active),
      .clock_divider_code (clock_reference_control_reg[2:0]),
      .tick               (tick)
   );

   //---------------------------------------------------------------------
   // Configuration registers
   //---------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         main_control_reg            <= adc_ctrl_pkg::REG_RESET;
         accumulation_control_reg    <= adc_ctrl_pkg::REG_RESET;
         clock_reference_control_reg <= adc_ctrl_pkg::REG_RESET;
         window_mode_control_reg     <= adc_ctrl_pkg::REG_RESET;
         sample_length_control_reg   <= adc_ctrl_pkg::REG_RESET;
         input_channel_select_reg    <= adc_ctrl_pkg::REG_RESET;
      end else if (reg_write) begin
         unique case (reg_addr)
            adc_ctrl_pkg::OFS_MAIN_CONTROL:
               main_control_reg <= reg_wdata & adc_ctrl_pkg::MASK_MAIN_CONTROL; // [R21]
            adc_ctrl_pkg::OFS_ACCUM_CONTROL:
               accumulation_control_reg <= reg_wdata & adc_ctrl_pkg::MASK_ACCUM_CONTROL;
            adc_ctrl_pkg::OFS_CLOCK_REF:
               clock_reference_control_reg <= reg_wdata & adc_ctrl_pkg::MASK_CLOCK_REF;
            adc_ctrl_pkg::OFS_WINDOW_MODE:
               window_mode_control_reg <= reg_wdata & adc_ctrl_pkg::MASK_WINDOW_MODE;
            adc_ctrl_pkg::OFS_SAMPLE_LENGTH:
               sample_length_control_reg <= reg_wdata & adc_ctrl_pkg::MASK_SAMPLE_LENGTH;
            adc_ctrl_pkg::OFS_INPUT_CHANNEL:
               input_channel_select_reg <= reg_wdata & adc_ctrl_pkg::MASK_INPUT_CHANNEL;
            default: ;
         endcase
      end
   end

   // Delay field is stepped by hardware; a software write takes precedence
   always_ff @(posedge clk) begin
      if (srst) begin
         delay_control_reg <= adc_ctrl_pkg::REG_RESET;
      end else if (wr_delay) begin
         delay_control_reg <= reg_wdata & adc_ctrl_pkg::MASK_DELAY_CONTROL;
      end else if (auto_delay_variation && state_reg == adc_ctrl_pkg::ST_CONVERT &&
                   convert_done) begin
         delay_control_reg[3:0] <= inter_sample_delay + 4'h1; // [R12]
      end
   end

   //---------------------------------------------------------------------
   // Startup delay request
   //---------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         enable_prev_reg <= 1'b0;
      end else begin
         enable_prev_reg <= enable_bit;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         startup_pending_reg <= 1'b0;
      end else if ((enable_bit && !enable_prev_reg) || deep_sleep_wake || // [R10] [R11]
                   (wr_clock && reg_wdata[5:4] == adc_ctrl_pkg::REF_INTERNAL &&
                    reference_select != adc_ctrl_pkg::REF_INTERNAL)) begin
         startup_pending_reg <= 1'b1;
      end else if (state_reg == adc_ctrl_pkg::ST_STARTUP && startup_end) begin
         startup_pending_reg <= 1'b0;
      end else if (state_reg == adc_ctrl_pkg::ST_IDLE && active && start_conversion &&
                   startup_ticks(startup_delay) == 9'h000) begin
         startup_pending_reg <= 1'b0;
      end
   end

   //---------------------------------------------------------------------
   // Conversion sequencer
   //---------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst || !enable_bit) begin
         state_reg <= adc_ctrl_pkg::ST_IDLE;
      end else if (active) begin
         unique case (state_reg)
            adc_ctrl_pkg::ST_IDLE: begin
               if (start_conversion) begin
                  state_reg <= (startup_pending_reg &&
                                startup_ticks(startup_delay) != 9'h000) ?
                               adc_ctrl_pkg::ST_STARTUP : adc_ctrl_pkg::ST_SAMPLE;
               end
            end
            adc_ctrl_pkg::ST_STARTUP: begin
               if (startup_end) begin
                  state_reg <= adc_ctrl_pkg::ST_SAMPLE; // [R10]
               end
            end
            adc_ctrl_pkg::ST_SAMPLE: begin
               if (sample_end) begin
                  state_reg <= adc_ctrl_pkg::ST_CONVERT; // [R16]
               end
            end
            adc_ctrl_pkg::ST_CONVERT: begin
               if (convert_done) begin
                  if (samples_left_reg > 7'h01) begin
                     state_reg <= (inter_sample_delay == 4'h0) ?
                                  adc_ctrl_pkg::ST_SAMPLE : adc_ctrl_pkg::ST_GAP;
                  end else if (continuous_conversion) begin
                     state_reg <= adc_ctrl_pkg::ST_SAMPLE; // [R4]
                  end else begin
                     state_reg <= adc_ctrl_pkg::ST_IDLE;
                  end
               end
            end
            adc_ctrl_pkg::ST_GAP: begin
               if (gap_end) begin
                  state_reg <= adc_ctrl_pkg::ST_SAMPLE; // [R13]
               end
            end
         endcase
      end
   end

   // Converter clock cycles spent in the current timed phase
   always_ff @(posedge clk) begin
      if (srst || !active || state_reg == adc_ctrl_pkg::ST_IDLE ||
          state_reg == adc_ctrl_pkg::ST_CONVERT) begin
         tick_count_reg <= 9'h000;
      end else if (tick) begin
         if ((state_reg == adc_ctrl_pkg::ST_STARTUP && startup_end) ||
             (state_reg == adc_ctrl_pkg::ST_SAMPLE && sample_end) ||
             (state_reg == adc_ctrl_pkg::ST_GAP && gap_end)) begin
            tick_count_reg <= 9'h000;
         end else begin
            tick_count_reg <= tick_count_reg + 9'h001;
         end
      end
   end

   // Sample count and accumulation
   always_ff @(posedge clk) begin
      if (srst || !enable_bit) begin
         samples_left_reg <= 7'h00;
         accum_reg        <= '0;
      end else if (active && state_reg == adc_ctrl_pkg::ST_IDLE && start_conversion) begin
         samples_left_reg <= sample_total(accumulation_count); // [R6]
         accum_reg        <= '0;
      end else if (active && state_reg == adc_ctrl_pkg::ST_CONVERT && convert_done) begin
         if (samples_left_reg > 7'h01) begin
            samples_left_reg <= samples_left_reg - 7'h01;
            if (resolution_select) begin
               accum_reg <= accum_reg + 16'(convert_data[9:2]); // [R3]
            end else begin
               accum_reg <= accum_reg + 16'(convert_data); // [R2]
            end
         end else begin
            samples_left_reg <= sample_total(accumulation_count);
            accum_reg        <= '0;
         end
      end
   end

   wire [RESULT_BITS-1:0] final_sum = resolution_select ?
                                      accum_reg + 16'(convert_data[9:2]) :
                                      accum_reg + 16'(convert_data);
   wire finishing = active && state_reg == adc_ctrl_pkg::ST_CONVERT && convert_done &&
                    samples_left_reg <= 7'h01;

   //---------------------------------------------------------------------
   // Results and flags
   //---------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         result <= '0;
      end else if (finishing) begin
         result <= final_sum; // [R2] [R3]
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         result_ready_flag <= 1'b0;
         window_flag       <= 1'b0;
      end else begin
         result_ready_flag <= finishing; // [R19]
         window_flag       <= finishing && window_match(window_mode, final_sum, // [R20] [R15]
                                                        window_low_threshold,
                                                        window_high_threshold);
      end
   end

   // Busy indication; a new start while busy is ignored except in the finishing cycle, where it wins over the clear
   always_ff @(posedge clk) begin
      if (srst || !enable_bit) begin
         start_conversion <= 1'b0;
      end else if (start_cmd) begin
         start_conversion <= 1'b1; // [R18]
      end else if (finishing && !continuous_conversion) begin
         start_conversion <= 1'b0; // [R18]
      end
   end

   //---------------------------------------------------------------------
   // Analog core drive
   //---------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         analog_cfg <= '0;
      end else begin
         analog_cfg.powered   <= active; // [R1] [R5]
         analog_cfg.reference <= reference_select; // [R8]
         analog_cfg.small_cap <= clock_reference_control_reg[adc_ctrl_pkg::BIT_SAMPLE_CAP]; // [R9]
         if (state_reg == adc_ctrl_pkg::ST_IDLE || finishing) begin
            analog_cfg.channel <= input_channel_select_reg[4:0]; // [R17]
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         sample_open   <= 1'b0;
         convert_start <= 1'b0;
      end else begin
         sample_open   <= active && (state_reg == adc_ctrl_pkg::ST_SAMPLE ||
                                     state_reg == adc_ctrl_pkg::ST_GAP); // [R13]
         convert_start <= active && state_reg == adc_ctrl_pkg::ST_SAMPLE && sample_end; // [R16]
      end
   end

   //---------------------------------------------------------------------
   // Register read port
   //---------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         reg_rdata <= 8'h00;
      end else if (reg_read) begin
         unique case (reg_addr)
            adc_ctrl_pkg::OFS_MAIN_CONTROL:  reg_rdata <= main_control_reg;
            adc_ctrl_pkg::OFS_ACCUM_CONTROL: reg_rdata <= accumulation_control_reg;
            adc_ctrl_pkg::OFS_CLOCK_REF:     reg_rdata <= clock_reference_control_reg;
            adc_ctrl_pkg::OFS_DELAY_CONTROL: reg_rdata <= delay_control_reg;
            adc_ctrl_pkg::OFS_WINDOW_MODE:   reg_rdata <= window_mode_control_reg;
            adc_ctrl_pkg::OFS_SAMPLE_LENGTH: reg_rdata <= sample_length_control_reg;
            adc_ctrl_pkg::OFS_INPUT_CHANNEL: reg_rdata <= input_channel_select_reg;
            adc_ctrl_pkg::OFS_COMMAND:       reg_rdata <= {7'h00, start_conversion}; // [R18]
            default:                         reg_rdata <= 8'h00; // [R21]
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end
endmodule

/* adc_conversion_control_assertions.sv */
// Port timing checker for the converter control block
`timescale 1ns/10ps
module adc_conversion_control_assertions #(parameter int RESULT_BITS = 16) (
   input wire logic                   clk, srst, reg_read, sample_open, convert_start,
   input wire logic                   convert_done, result_ready_flag, window_flag,
   input wire logic                   start_conversion,
   input wire logic [7:0]             reg_rdata,
   input wire logic [RESULT_BITS-1:0] result);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   sequence s_start_pulse;
      convert_start ##1 !convert_start;
   endsequence
   a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
      else $error("read data not idle");
   a_ready_done: assert property (result_ready_flag |-> $past(convert_done))
      else $error("ready without done");
   a_ready_pulse: assert property (result_ready_flag |=> !result_ready_flag)
      else $error("ready held");
   a_window_ready: assert property (window_flag |-> result_ready_flag)
      else $error("window flag off the end");
   a_start_pulse: assert property (convert_start |-> s_start_pulse)
      else $error("start not a pulse");
   a_start_busy: assert property (convert_start |-> start_conversion)
      else $error("start while not busy");
   a_start_sampled: assert property (convert_start |-> $past(sample_open))
      else $error("start without sample phase");
   a_reset_quiet: assert property ($fell(srst) |-> !start_conversion && result == 0)
      else $error("outputs not clear after reset");
endmodule
bind adc_conversion_control adc_conversion_control_assertions #(.RESULT_BITS(RESULT_BITS))
   i_chk (.clk(clk), .srst(srst), .reg_read(reg_read), .sample_open(sample_open),
   .convert_start(convert_start), .convert_done(convert_done), .result(result),
   .result_ready_flag(result_ready_flag), .window_flag(window_flag),
   .start_conversion(start_conversion), .reg_rdata(reg_rdata));

/* adc_conversion_control_tb.sv */
// Self-checking bench for the converter control block
`timescale 1ns/10ps
module adc_conversion_control_tb;
   logic clk = 1'b0, srst = 1'b1, reg_write = 1'b0, reg_read = 1'b0, standby_sleep = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, d, rdata;
   logic [9:0] value = 10'h3f0, cdata;
   logic [15:0] res, result, wlo = 16'h0100, whi = 16'h0200;
   logic w, ready, wflag, busy, done, cstart, sopen, wake = 1'b0;
   adc_ctrl_pkg::analog_cfg_t cfg;
   logic [7:0] m [7] = '{8'h87, 8'h07, 8'h77, 8'hff, 8'h07, 8'h1f, 8'h1f};
   logic [4:0] we = 5'b10010;
   int fails = 0, n_checks = 0, k;
   always #25 clk = ~clk;
   adc_conversion_control i_dut (.clk(clk), .srst(srst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(rdata),
      .standby_sleep(standby_sleep), .deep_sleep_wake(wake), .window_low_threshold(wlo),
      .window_high_threshold(whi), .analog_cfg(cfg), .sample_open(sopen),
      .convert_start(cstart), .convert_done(done), .convert_data(cdata), .result(result),
      .result_ready_flag(ready), .window_flag(wflag), .start_conversion(busy));
   adc_core_model i_core (.clk(clk), .convert_start(cstart), .value(value),
      .convert_done(done), .convert_data(cdata));
   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk); reg_addr <= a; reg_wdata <= v; reg_write <= 1'b1;
      @(posedge clk); reg_write <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk); reg_addr <= a; reg_read <= 1'b1;
      @(posedge clk); reg_read <= 1'b0;
      @(posedge clk); v = rdata;
   endtask
   // Waits for the result pulse and captures what stands beside it
   task wait_rdy;
      k = 0;
      while (ready !== 1'b1 && k < 3000) begin @(posedge clk); k++; end
      if (k == 3000) fails++;
      res = result; w = wflag;
      @(posedge clk);
   endtask
   task go;
      wr(8'h08, 8'h01);
      wait_rdy;
   endtask
   task finish_test;
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #2000000; fails++; finish_test;
   end
   initial begin
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      for (int i = 0; i < 7; i++) begin
         rd(8'(i), d); chk(16'(d), 16'h0000);
         wr(8'(i), 8'hff); rd(8'(i), d); chk(16'(d), 16'(m[i]));
         wr(8'(i), 8'h00);
      end
      wr(8'h07, 8'hff); rd(8'h07, d); chk(16'(d), 16'h0000);
      wr(8'h00, 8'h01); wr(8'h01, 8'h01); go;
      chk(res, 16'h07e0);
      chk(16'(busy), 16'h0000);
      wr(8'h00, 8'h05); wr(8'h01, 8'h00);
      for (int i = 0; i < 5; i++) begin
         wr(8'h04, 8'(i)); go;
         chk(res, 16'h00fc);
         chk(16'(w), 16'(we[i]));
      end
      wr(8'h03, 8'h3f); wake <= 1'b1; @(posedge clk); wake <= 1'b0;
      go; chk(16'(k > 32), 16'h0001);
      rd(8'h03, d); chk(16'(d), 16'h0030);
      wr(8'h05, 8'h1f); go; chk(16'(k > 64), 16'h0001); wr(8'h05, 8'h00);
      wr(8'h02, 8'h07); go; chk(16'(k > 256), 16'h0001);
      wr(8'h02, 8'h50); repeat (2) @(posedge clk);
      chk(16'(cfg.small_cap), 16'h0001);
      chk(16'(cfg.reference), 16'h0001);
      standby_sleep <= 1'b1; repeat (3) @(posedge clk);
      chk(16'(cfg.powered), 16'h0000);
      wr(8'h00, 8'h85); repeat (2) @(posedge clk);
      chk(16'(cfg.powered), 16'h0001);
      standby_sleep <= 1'b0;
      wr(8'h03, 8'h00); wr(8'h00, 8'h03); go; wr(8'h06, 8'h05); repeat (2) @(posedge clk);
      chk(16'(cfg.channel), 16'h0000);
      wait_rdy; chk(16'(cfg.channel), 16'h0005);
      chk(res, 16'h03f0);
      chk(16'(busy), 16'h0001);
      wr(8'h00, 8'h00); repeat (2) @(posedge clk);
      chk(16'(busy), 16'h0000);
      finish_test;
   end
endmodule

/* adc_core_model.sv */
// Behavioural model of the analog sampling core
`timescale 1ns/10ps
module adc_core_model #(parameter int LAT = 3) (
   input  wire logic       clk,
   input  wire logic       convert_start,
   input  wire logic [9:0] value,
   output logic            convert_done,
   output logic [9:0]      convert_data);
   int cnt = 0;
   initial convert_done = 1'b0;
   initial convert_data = 10'h155;
   // Data toggles outside the answer cycle so a stale value never passes
   always @(posedge clk) begin
      convert_done <= (cnt == 1);
      convert_data <= (cnt == 1) ? value : ~convert_data;
      cnt <= convert_start ? LAT : ((cnt > 0) ? cnt - 1 : 0);
   end
endmodule

/* adc_ctrl_pkg.sv */
// Constants, types and field layout for the converter control block
//------------------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------------------
// Summary of operation
// [R1] Standby run bit keeps converter alive in standby
// [R2] Resolution zero stores full ten-bit values
// [R3] Resolution one keeps eight upper bits only
// [R4] Continuous mode restarts after each completed result
// [R5] Enable bit turns converter on and off
// [R6] Accumulation code sums 1 to 64 samples
// [R7] Converter clock is peripheral clock over 2..256
// [R8] Reference code picks internal or supply
// [R9] Capacitor bit drives analog capacitance choice
// [R10] Startup delay after enable or internal reference
// [R11] Startup delay also after deep sleep wake
// [R12] Auto variation increments inter-sample delay, wraps
// [R13] Inter-sample delay cycles with capacitor open
// [R14] Window mode selects flag comparison
// [R15] Window compares full sixteen-bit accumulated result
// [R16] Sampling lasts two plus extension cycles
// [R17] Channel change applies after current conversion
// [R18] Start bit reads one while busy
// [R19] Result ready flag set per measurement
// [R20] Window flag evaluated at conversion end
// [R21] Unused bits read zero, writes ignored
package adc_ctrl_pkg;

   //---------------------------------------------------------------------
   // Register offsets
   //---------------------------------------------------------------------
   localparam logic [7:0] OFS_MAIN_CONTROL   = 8'h00;
   localparam logic [7:0] OFS_ACCUM_CONTROL  = 8'h01;
   localparam logic [7:0] OFS_CLOCK_REF      = 8'h02;
   localparam logic [7:0] OFS_DELAY_CONTROL  = 8'h03;
   localparam logic [7:0] OFS_WINDOW_MODE    = 8'h04;
   localparam logic [7:0] OFS_SAMPLE_LENGTH  = 8'h05;
   localparam logic [7:0] OFS_INPUT_CHANNEL  = 8'h06;
   localparam logic [7:0] OFS_COMMAND        = 8'h08;

   //---------------------------------------------------------------------
   // Writable bit masks and reset values
   //---------------------------------------------------------------------
   localparam logic [7:0] MASK_MAIN_CONTROL  = 8'h87;
   localparam logic [7:0] MASK_ACCUM_CONTROL = 8'h07;
   localparam logic [7:0] MASK_CLOCK_REF     = 8'h77;
   localparam logic [7:0] MASK_DELAY_CONTROL = 8'hff;
   localparam logic [7:0] MASK_WINDOW_MODE   = 8'h07;
   localparam logic [7:0] MASK_SAMPLE_LENGTH = 8'h1f;
   localparam logic [7:0] MASK_INPUT_CHANNEL = 8'h1f;
   localparam logic [7:0] REG_RESET          = 8'h00;

   //---------------------------------------------------------------------
   // Field positions
   //---------------------------------------------------------------------
   localparam int BIT_STANDBY_RUN  = 7;
   localparam int BIT_RESOLUTION   = 2;
   localparam int BIT_CONTINUOUS   = 1;
   localparam int BIT_ENABLE       = 0;
   localparam int BIT_SAMPLE_CAP   = 6;
   localparam int POS_REFERENCE    = 4;
   localparam int POS_STARTUP      = 5;
   localparam int BIT_AUTO_DELAY   = 4;
   localparam int BIT_START_CONV   = 0;

   //---------------------------------------------------------------------
   // Codes and timing counts
   //---------------------------------------------------------------------
   localparam logic [1:0] REF_INTERNAL       = 2'h0;
   localparam logic [1:0] REF_SUPPLY         = 2'h1;
   localparam logic [2:0] WIN_NONE           = 3'h0;
   localparam logic [2:0] WIN_BELOW          = 3'h1;
   localparam logic [2:0] WIN_ABOVE          = 3'h2;
   localparam logic [2:0] WIN_INSIDE         = 3'h3;
   localparam logic [2:0] WIN_OUTSIDE        = 3'h4;
   localparam logic [2:0] ACCUM_MAX_CODE     = 3'h6;
   localparam logic [2:0] STARTUP_MAX_CODE   = 3'h5;
   localparam logic [8:0] STARTUP_BASE_TICKS = 9'h010;
   localparam logic [8:0] SAMPLE_BASE_TICKS  = 9'h002;

   typedef enum {ST_IDLE, ST_STARTUP, ST_SAMPLE, ST_CONVERT, ST_GAP} conv_state_t;

   // Configuration handed to the analog core
   typedef struct packed {
      logic       powered;
      logic [1:0] reference;
      logic       small_cap;
      logic [4:0] channel;
   } analog_cfg_t;

endpackage

/* clock_prescaler.sv */
// Converter clock tick generator dividing the peripheral clock
`timescale 1ns/10ps
module clock_prescaler #(
   parameter int MAX_CODE = 7
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       srst,
   // Control
   input  wire logic       run,
   input  wire logic [2:0] clock_divider_code,
   // Tick out
   output logic            tick
);
   initial begin
      if (MAX_CODE < 0 || MAX_CODE > 7) begin
         $error("clock_prescaler: MAX_CODE out of range");
      end
   end

   logic [7:0] count_reg;

   function automatic logic [7:0] last_count(input logic [2:0] code);
      last_count = 8'((9'h002 << code) - 9'h001);
   endfunction

   always_ff @(posedge clk) begin
      if (srst || !run) begin
         count_reg <= 8'h00;
      end else if (count_reg >= last_count(clock_divider_code)) begin
         count_reg <= 8'h00; // [R7]
      end else begin
         count_reg <= count_reg + 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (srst || !run) begin
         tick <= 1'b0;
      end else begin
         tick <= (count_reg >= last_count(clock_divider_code)); // [R7]
      end
   end
endmodule
